// ===== dv/sysio_bank_assertions.sv
// assertion checker for the system i/o bank ports
`timescale 1ns/100ps
module sysio_bank_assertions
    import sysio_pkg::*;
#(
    parameter int RESET_PULSE = 100
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire sysio_req_type acc,
    input wire logic acc_ack_r,
    input wire logic [15:0] acc_rdata_r,
    input wire sysio_front_in_type front_in,
    input wire sysio_cause_type causes,
    input wire logic front_reset_in,
    input wire logic alarm_output_r,
    input wire logic backplane_reset_r,
    input wire logic cpu_reset_r
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    logic [5:0] cfg_r;
    logic [7:0] bp_cnt_r;
    logic [7:0] cpu_cnt_r;
    logic [3:0] fr_age_r;
    logic rd_req;
    assign rd_req = acc.req && !acc.wr;
    // shadow of the stored alarm bits; only masked bits move
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= 6'h00;
        end else if (acc.req && acc.wr && acc.item == ITEM_ALARM_CFG) begin
            cfg_r <= (cfg_r & ~acc.wdata[13:8]) | (acc.wdata[5:0] & acc.wdata[13:8]);
        end
    end
    // high-time counters; a retrigger only stretches a pulse, so a floor is checked
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bp_cnt_r <= 8'h00;
            cpu_cnt_r <= 8'h00;
        end else begin
            bp_cnt_r <= backplane_reset_r ? bp_cnt_r + 8'h01 : 8'h00;
            cpu_cnt_r <= cpu_reset_r ? cpu_cnt_r + 8'h01 : 8'h00;
        end
    end
    // cycles since the front reset pin last rose, saturating
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fr_age_r <= 4'hf;
        end else if ($rose(front_reset_in)) begin
            fr_age_r <= 4'h0;
        end else if (fr_age_r != 4'hf) begin
            fr_age_r <= fr_age_r + 4'h1;
        end
    end
    sequence rd_s(logic [3:0] it);
        rd_req && acc.item == it;
    endsequence
    // pins must sit still long enough to pass the synchroniser
    sequence pins_still_s;
        $stable(front_in)[*3];
    endsequence
    sequence quiet_s;
        ($stable(causes) && $stable(cfg_r))[*5];
    endsequence
    AST_ACK_PULSE: assert property (acc.req |=> acc_ack_r)
        else $error("no ack after request");
    AST_RDATA_IDLE: assert property (!rd_req |=> acc_rdata_r == 16'h0000)
        else $error("read data not zero outside reads");
    AST_ALARM_READ: assert property (rd_s(ITEM_ALARM_CFG) |=> acc_rdata_r == {10'h000, $past(cfg_r)})
        else $error("alarm config read mismatch");
    AST_FIN_READ: assert property (pins_still_s ##0 rd_s(ITEM_FRONT_IN) |=> acc_rdata_r == {9'h000, $past(front_in)})
        else $error("front input word mismatch");
    AST_FOUT_ZERO: assert property (rd_s(ITEM_FRONT_OUT) |=> acc_rdata_r[15:10] == 6'h00 && acc_rdata_r[7:4] == 4'h0)
        else $error("front output unused bits set");
    AST_ALARM_OUT: assert property (quiet_s |-> alarm_output_r == (cfg_r[0] && (cfg_r[1] || |(cfg_r[5:2] & causes))))
        else $error("alarm output level wrong");
    AST_BP_WIDTH: assert property ($fell(backplane_reset_r) |-> bp_cnt_r >= RESET_PULSE)
        else $error("backplane reset pulse short");
    AST_CPU_WIDTH: assert property ($fell(cpu_reset_r) |-> cpu_cnt_r >= RESET_PULSE)
        else $error("cpu reset pulse short");
    AST_CPU_CAUSE: assert property ($rose(cpu_reset_r) |-> fr_age_r <= 4'h5)
        else $error("cpu reset without front reset");
endmodule : sysio_bank_assertions

bind sysio_bank sysio_bank_assertions #(.RESET_PULSE(RESET_PULSE)) u_chk (.mclk(mclk), .arst_n(arst_n),
    .acc(acc), .acc_ack_r(acc_ack_r), .acc_rdata_r(acc_rdata_r), .front_in(front_in), .causes(causes),
    .front_reset_in(front_reset_in), .alarm_output_r(alarm_output_r), .backplane_reset_r(backplane_reset_r),
    .cpu_reset_r(cpu_reset_r));

// ===== dv/system_io_status_config_bank_test.sv
// self-checking bench for the system i/o bank
`timescale 1ns/100ps
module system_io_status_config_bank_test
    import sysio_pkg::*;
;
    localparam int PW = 4;
    // identification texts; values arbitrary
    localparam logic [127:0] MODEL_T = {"UNIT-X", 80'h0};
    localparam logic [127:0] FW_T = {"9.87.65", 72'h0};
    logic [15:0] mw [5] = '{16'h3f3f, 16'h0100, 16'hc0ff, 16'h2000, 16'h3f00};
    logic [15:0] me [5] = '{16'h003f, 16'h003e, 16'h003e, 16'h001e, 16'h0000};
    logic [15:0] aw [4] = '{16'h0303, 16'h0100, 16'h0101, 16'h0200};
    logic [15:0] rc [6] = '{16'h0032, 16'h0033, 16'h0036, 16'h003a, 16'h003e, 16'h0033};
    int fo_pos [6] = '{0, 1, 2, 3, 8, 9};
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    sysio_req_type acc = '0;
    sysio_front_in_type front_in = '0;
    sysio_front_out_type front_out = '0;
    sysio_cause_type causes = '0;
    sysio_health_type health = '0;
    logic cpu_fail = 1'b0;
    logic front_reset_in = 1'b0;
    logic acc_ack_r;
    logic [15:0] acc_rdata_r;
    logic alarm_output_r;
    logic backplane_reset_r;
    logic cpu_reset_r;
    int err_total = 0;
    int compares = 0;
    int bp_n;
    int cpu_n;

    sysio_bank #(.MODEL_TEXT(MODEL_T), .FW_TEXT(FW_T), .RESET_PULSE(PW)) DUT (.mclk(mclk), .arst_n(arst_n),
        .acc(acc), .acc_ack_r(acc_ack_r), .acc_rdata_r(acc_rdata_r), .front_in(front_in), .front_out(front_out),
        .causes(causes), .health(health), .cpu_fail(cpu_fail), .front_reset_in(front_reset_in),
        .alarm_output_r(alarm_output_r), .backplane_reset_r(backplane_reset_r), .cpu_reset_r(cpu_reset_r));

    // 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    // one access: request held over the taking edge, answer looked at one cycle on
    task automatic op(input logic w, input logic [3:0] it, input logic [3:0] ix, input logic [15:0] wd);
        @(posedge mclk);
        acc <= {1'b1, w, it, ix, wd};
        @(posedge mclk);
        acc.req <= 1'b0;
        #1;
    endtask : op

    task automatic rdchk(input logic [3:0] it, input logic [3:0] ix, input logic [15:0] exp);
        op(1'b0, it, ix, 16'h0000);
        chk({15'h0, acc_ack_r}, 16'h0001);
        chk(acc_rdata_r, exp);
    endtask : rdchk

    // alarm config write, cause pins set, then the settled output level
    task automatic al(input logic [15:0] wd, input logic [3:0] cs, input logic exp);
        op(1'b1, ITEM_ALARM_CFG, 4'h0, wd);
        causes <= cs;
        cyc(8);
        #1;
        chk({15'h0, alarm_output_r}, {15'h0, exp});
    endtask : al

    // raise one reset source pin and count the high cycles of both reset outputs
    task automatic pulse(input logic front);
        bp_n = 0;
        cpu_n = 0;
        @(posedge mclk);
        if (front) begin
            front_reset_in <= 1'b1;
        end else begin
            cpu_fail <= 1'b1;
        end
        repeat (20) begin
            @(posedge mclk);
            #1;
            bp_n += int'(backplane_reset_r === 1'b1);
            cpu_n += int'(cpu_reset_r === 1'b1);
        end
        @(posedge mclk);
        front_reset_in <= 1'b0;
        cpu_fail <= 1'b0;
        cyc(4);
    endtask : pulse

    // watchdog: the whole run needs well under 5000 cycles
    initial begin
        cyc(20000);
        err_total++;
        finish_test();
    end

    initial begin
        cyc(16);
        arst_n <= 1'b1;
        rdchk(ITEM_ALARM_CFG, 4'h0, 16'h0000);
        rdchk(ITEM_RESET_CFG, 4'h0, RESET_CFG_RESET);
        for (int i = 0; i < 5; i++) begin
            op(1'b1, ITEM_ALARM_CFG, 4'h0, mw[i]);
            rdchk(ITEM_ALARM_CFG, 4'h0, me[i]);
        end
        // a write to a read-only item changes nothing; an unknown item reads zero
        op(1'b1, ITEM_FRONT_IN, 4'h0, 16'hffff);
        rdchk(ITEM_ALARM_CFG, 4'h0, 16'h0000);
        rdchk(4'hf, 4'h0, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            al(aw[i], 4'h0, i[0] == 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            al(16'h3f01 | (16'h0004 << i), 4'h1 << i, 1'b1);
            al(16'h3f01 | (16'h0004 << i), ~(4'h1 << i), 1'b0);
        end
        al(16'h0100, 4'hf, 1'b0);
        for (int i = 0; i < 7; i++) begin
            front_in <= 7'h01 << i;
            cyc(4);
            rdchk(ITEM_FRONT_IN, 4'h0, 16'h0001 << i);
        end
        for (int i = 0; i < 6; i++) begin
            front_out <= 6'h01 << i;
            cyc(4);
            rdchk(ITEM_FRONT_OUT, 4'h0, 16'h0001 << fo_pos[i]);
        end
        for (int i = 0; i < 6; i++) begin
            op(1'b1, ITEM_RESET_CFG, 4'h0, rc[i]);
            rdchk(ITEM_RESET_CFG, 4'h0, rc[i]);
            pulse(i > 1);
            chk(16'(bp_n), (i == 1 || i == 2 || i == 4) ? 16'(PW) : 16'h0000);
            chk(16'(cpu_n), (i == 3 || i == 4) ? 16'(PW) : 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            health.mains_sel <= 2'(i);
            cyc(4);
            rdchk(ITEM_MAINS_FREQ, 4'h0, (i == 3) ? CODE_FAIL : 16'(i));
        end
        health.mains_fail <= 1'b1;
        health.ac_good <= 1'b1;
        health.primary_good <= 1'b1;
        health.addon_good <= 3'h3;
        health.addon_present <= 3'h5;
        health.fan_good <= 1'b1;
        cyc(4);
        rdchk(ITEM_MAINS_FREQ, 4'h0, CODE_FAIL);
        rdchk(ITEM_SUPPLY_HEALTH, 4'h0, CODE_GOOD);
        rdchk(ITEM_SUPPLY_HEALTH, 4'h1, CODE_GOOD);
        rdchk(ITEM_SUPPLY_HEALTH, 4'h2, CODE_GOOD);
        rdchk(ITEM_SUPPLY_HEALTH, 4'h3, CODE_ABSENT);
        rdchk(ITEM_SUPPLY_HEALTH, 4'h4, CODE_FAIL);
        rdchk(ITEM_FAN_HEALTH, 4'h0, CODE_GOOD);
        health.ac_good <= 1'b0;
        health.fan_good <= 1'b0;
        cyc(4);
        rdchk(ITEM_SUPPLY_HEALTH, 4'h0, CODE_FAIL);
        rdchk(ITEM_FAN_HEALTH, 4'h0, CODE_FAIL);
        for (int i = 0; i < 16; i++) begin
            rdchk(ITEM_MODEL_STR, 4'(i), {8'h00, MODEL_T[8*(15-i)+:8]});
            rdchk(ITEM_FW_STR, 4'(i), {8'h00, FW_T[8*(15-i)+:8]});
        end
        finish_test();
    end
endmodule : system_io_status_config_bank_test

// ===== shared/sysio_pkg.sv
// package: item codes, field positions, reset values and timing for the system i/o bank
package sysio_pkg;

    // clock and timing
    localparam int CLK_PERIOD_PS = 10000;
    localparam int RST_PULSE_NS = 1000;
    localparam int RST_PULSE_CYCLES = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // item selector of the access port
    localparam logic [3:0] ITEM_ALARM_CFG = 4'h0;
    localparam logic [3:0] ITEM_FRONT_IN = 4'h1;
    localparam logic [3:0] ITEM_FRONT_OUT = 4'h2;
    localparam logic [3:0] ITEM_RESET_CFG = 4'h3;
    localparam logic [3:0] ITEM_MAINS_FREQ = 4'h4;
    localparam logic [3:0] ITEM_SUPPLY_HEALTH = 4'h5;
    localparam logic [3:0] ITEM_FAN_HEALTH = 4'h6;
    localparam logic [3:0] ITEM_MODEL_STR = 4'h7;
    localparam logic [3:0] ITEM_FW_STR = 4'h8;

    // alarm output configuration fields
    localparam int ALARM_EN_BIT = 0;
    localparam int ALARM_ALWAYS_BIT = 1;
    localparam int ALARM_OVV_BIT = 2;
    localparam int ALARM_OVC_BIT = 3;
    localparam int ALARM_UNV_BIT = 4;
    localparam int ALARM_TRIP_BIT = 5;
    localparam int ALARM_CTRL_W = 6;
    localparam int ALARM_MASK_LSB = 8;
    localparam logic [15:0] ALARM_CFG_RESET = 16'h0000;

    // reset routing configuration fields
    localparam int RST_CPU_FAIL_BIT = 0;
    localparam int RST_FRONT_BP_BIT = 2;
    localparam int RST_FRONT_CPU_BIT = 3;
    localparam logic [15:0] RESET_CFG_RESET = 16'h0032;

    // front output word fields
    localparam int FOUT_FAN_BIT = 8;
    localparam int FOUT_OVT_BIT = 9;

    // signed health and frequency codes
    localparam logic [15:0] CODE_FAIL = 16'hffff;
    localparam logic [15:0] CODE_ABSENT = 16'h0000;
    localparam logic [15:0] CODE_GOOD = 16'h0001;
    localparam logic [15:0] FREQ_50 = 16'h0000;
    localparam logic [15:0] FREQ_60 = 16'h0001;
    localparam logic [15:0] FREQ_400 = 16'h0002;
    localparam logic [1:0] FSEL_50 = 2'h0;
    localparam logic [1:0] FSEL_60 = 2'h1;
    localparam logic [1:0] FSEL_400 = 2'h2;

    // health slots: ac, primary, add-on 0..2
    localparam int ADDON_COUNT = 3;
    localparam int HEALTH_SLOTS = 2 + ADDON_COUNT;
    localparam int STR_CHARS = 16;

    // front-panel input pins
    typedef struct packed {
        logic nim_sel;
        logic local_enable;
        logic remote_enable;
        logic interlock;
        logic kill;
        logic current_setpoint_sel;
        logic voltage_setpoint_sel;
    } sysio_front_in_type;

    // front-panel output conditions
    typedef struct packed {
        logic over_temperature_flag;
        logic fan_fail;
        logic channel_on_flag;
        logic over_voltage_flag;
        logic under_voltage_flag;
        logic over_current_flag;
    } sysio_front_out_type;

    // alarm causes
    typedef struct packed {
        logic trip;
        logic under_voltage_cause;
        logic over_current_cause;
        logic over_voltage_cause;
    } sysio_cause_type;

    // supply, fan and mains monitors
    typedef struct packed {
        logic [ADDON_COUNT-1:0] addon_present;
        logic [ADDON_COUNT-1:0] addon_good;
        logic primary_good;
        logic ac_good;
        logic fan_good;
        logic mains_fail;
        logic [1:0] mains_sel;
    } sysio_health_type;

    // access port request
    typedef struct packed {
        logic req;
        logic wr;
        logic [3:0] item;
        logic [3:0] index;
        logic [15:0] wdata;
    } sysio_req_type;

endpackage : sysio_pkg

// ===== src/sysio_bank.sv
// system i/o status and configuration bank with alarm and reset routing
`timescale 1ns/100ps
module sysio_bank
    import sysio_pkg::*;
#(
    // identification strings, first character in the top byte; values arbitrary
    parameter logic [8*STR_CHARS-1:0] MODEL_TEXT = {"MODEL-A", 72'h0},
    parameter logic [8*STR_CHARS-1:0] FW_TEXT = {"0.00.00", 72'h0},
    parameter int RESET_PULSE = RST_PULSE_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire sysio_req_type acc,
    output logic acc_ack_r,
    output logic [15:0] acc_rdata_r,
    input wire sysio_front_in_type front_in,
    input wire sysio_front_out_type front_out,
    input wire sysio_cause_type causes,
    input wire sysio_health_type health,
    input wire logic cpu_fail,
    input wire logic front_reset_in,
    output logic alarm_output_r,
    output logic backplane_reset_r,
    output logic cpu_reset_r
);

    localparam int FIN_W = $bits(sysio_front_in_type);
    localparam int FOUT_W = $bits(sysio_front_out_type);
    localparam int CAUSE_W = $bits(sysio_cause_type);
    localparam int HEALTH_W = $bits(sysio_health_type);
    localparam int SYNC_W = FIN_W + FOUT_W + CAUSE_W + HEALTH_W + 2;
    localparam logic [15:0] PULSE_LOAD = 16'(RESET_PULSE);

    // synchronised pin images
    logic [SYNC_W-1:0] sync_vec;
    sysio_front_in_type fin_s;
    sysio_front_out_type fout_s;
    sysio_cause_type cause_s;
    sysio_health_type health_s;
    logic cpu_fail_s;
    logic front_reset_s;

    // every pin crosses two flops before any logic looks at it
    sysio_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .async_in({front_in,
            front_out,
            causes,
            health,
            cpu_fail,
            front_reset_in}),
        .sync_out(sync_vec)
    );

    // unpack in the same order as the concatenation above
    assign {fin_s,
        fout_s,
        cause_s,
        health_s,
        cpu_fail_s,
        front_reset_s} = sync_vec;

    // configuration storage
    logic [ALARM_CTRL_W-1:0] alarm_ctrl_r;
    logic [ALARM_CTRL_W-1:0] alarm_ctrl_nxt;
    logic [15:0] reset_cfg_r;
    logic alarm_wr;
    logic reset_wr;

    assign alarm_wr = acc.req && acc.wr && (acc.item == ITEM_ALARM_CFG);
    assign reset_wr = acc.req && acc.wr && (acc.item == ITEM_RESET_CFG);

    // masked write: a control bit moves only where its mask bit is one
    // a write with every mask bit clear is legal and leaves the word untouched
    always_comb begin
        alarm_ctrl_nxt = alarm_ctrl_r;
        if (alarm_wr) begin
            for (int i = 0; i < ALARM_CTRL_W; i++) begin
                if (acc.wdata[ALARM_MASK_LSB + i]) begin
                    alarm_ctrl_nxt[i] = acc.wdata[i];
                end
            end
        end
    end

    // alarm configuration register; mask and unused bits are never kept
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_ctrl_r <= ALARM_CFG_RESET[ALARM_CTRL_W-1:0];
        end else begin
            alarm_ctrl_r <= alarm_ctrl_nxt;
        end
    end

    // reset routing register is stored as written; only bits 0, 2, 3 act
    // bits 1, 4 and 5 are not checked here; software is trusted to keep them set
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reset_cfg_r <= RESET_CFG_RESET;
        end else if (reset_wr) begin
            reset_cfg_r <= acc.wdata;
        end
    end

    // alarm output: master enable gates the forced level and the selected causes
    logic cause_hit;
    assign cause_hit = (alarm_ctrl_r[ALARM_OVV_BIT] && cause_s.over_voltage_cause)
        || (alarm_ctrl_r[ALARM_OVC_BIT] && cause_s.over_current_cause)
        || (alarm_ctrl_r[ALARM_UNV_BIT] && cause_s.under_voltage_cause)
        || (alarm_ctrl_r[ALARM_TRIP_BIT] && cause_s.trip);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_output_r <= 1'b0;
        end else begin
            alarm_output_r <= alarm_ctrl_r[ALARM_EN_BIT]
                && (alarm_ctrl_r[ALARM_ALWAYS_BIT] || cause_hit);
        end
    end

    // edge detectors on the already synchronised fault and reset levels
    // a level held high fires once, so a stuck pin cannot hold the backplane in reset
    logic cpu_fail_d_r;
    logic front_reset_d_r;
    logic cpu_fail_rise;
    logic front_reset_rise;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_fail_d_r <= 1'b0;
            front_reset_d_r <= 1'b0;
        end else begin
            cpu_fail_d_r <= cpu_fail_s;
            front_reset_d_r <= front_reset_s;
        end
    end

    assign cpu_fail_rise = cpu_fail_s && !cpu_fail_d_r;
    assign front_reset_rise = front_reset_s && !front_reset_d_r;

    // reset pulse timers; a new trigger restarts the full pulse width
    logic [15:0] bp_cnt_r;
    logic [15:0] cpu_cnt_r;
    logic bp_trig;
    logic cpu_trig;

    assign bp_trig = (cpu_fail_rise && reset_cfg_r[RST_CPU_FAIL_BIT])
        || (front_reset_rise && reset_cfg_r[RST_FRONT_BP_BIT]);
    assign cpu_trig = front_reset_rise && reset_cfg_r[RST_FRONT_CPU_BIT];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bp_cnt_r <= 16'h0000;
        end else if (bp_trig) begin
            bp_cnt_r <= PULSE_LOAD;
        end else if (bp_cnt_r != 16'h0000) begin
            bp_cnt_r <= bp_cnt_r - 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_cnt_r <= 16'h0000;
        end else if (cpu_trig) begin
            cpu_cnt_r <= PULSE_LOAD;
        end else if (cpu_cnt_r != 16'h0000) begin
            cpu_cnt_r <= cpu_cnt_r - 16'h0001;
        end
    end

    // reset outputs are registered so they never glitch on the backplane;
    // the trigger cycle is the first of the pulse, so the output drops when the counter reaches one
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            backplane_reset_r <= 1'b0;
        end else begin
            backplane_reset_r <= bp_trig || (bp_cnt_r > 16'h0001);
        end
    end

    // processor reset pulse, same width and timing as the backplane one
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_reset_r <= 1'b0;
        end else begin
            cpu_reset_r <= cpu_trig || (cpu_cnt_r > 16'h0001);
        end
    end

    // status words built from synchronised pins
    logic [15:0] front_in_word;
    logic [15:0] front_out_word;
    logic [15:0] mains_code;
    logic [15:0] fan_code;
    logic [15:0] health_code [HEALTH_SLOTS];

    assign front_in_word = {9'h000,
        fin_s.nim_sel,
        fin_s.local_enable,
        fin_s.remote_enable,
        fin_s.interlock,
        fin_s.kill,
        fin_s.current_setpoint_sel,
        fin_s.voltage_setpoint_sel};

    assign front_out_word = {6'h00,
        fout_s.over_temperature_flag,
        fout_s.fan_fail,
        4'h0,
        fout_s.channel_on_flag,
        fout_s.over_voltage_flag,
        fout_s.under_voltage_flag,
        fout_s.over_current_flag};

    // mains frequency code; an unknown selector counts as a failure
    always_comb begin
        mains_code = CODE_FAIL;
        if (!health_s.mains_fail) begin
            case (health_s.mains_sel)
                FSEL_50: mains_code = FREQ_50;
                FSEL_60: mains_code = FREQ_60;
                FSEL_400: mains_code = FREQ_400;
                default: mains_code = CODE_FAIL;
            endcase
        end
    end

    assign fan_code = health_s.fan_good ? CODE_GOOD : CODE_FAIL;

    // ac and primary are always fitted; add-on slots may be empty
    assign health_code[0] = health_s.ac_good ? CODE_GOOD : CODE_FAIL;
    assign health_code[1] = health_s.primary_good ? CODE_GOOD : CODE_FAIL;
    genvar s;
    generate
        for (s = 0; s < ADDON_COUNT; s = s + 1) begin : g_addon
            assign health_code[2 + s] = !health_s.addon_present[s] ? CODE_ABSENT
                : (health_s.addon_good[s] ? CODE_GOOD : CODE_FAIL);
        end
    endgenerate

    // one character per read, index 0 is the first character
    function automatic logic [15:0] sysio_char(input logic [8*STR_CHARS-1:0] text, input logic [3:0] idx);
        logic [7:0] ch;
        ch = text[8*(STR_CHARS-1-int'(idx)) +: 8];
        return {8'h00, ch};
    endfunction : sysio_char

    // read multiplexer; unknown items and out-of-range slots read zero
    logic [15:0] rd_word;
    always_comb begin
        rd_word = 16'h0000;
        case (acc.item)
            ITEM_ALARM_CFG: rd_word = {10'h000, alarm_ctrl_r};
            ITEM_FRONT_IN: rd_word = front_in_word;
            ITEM_FRONT_OUT: rd_word = front_out_word;
            ITEM_RESET_CFG: rd_word = reset_cfg_r;
            ITEM_MAINS_FREQ: rd_word = mains_code;
            ITEM_SUPPLY_HEALTH: begin
                if (int'(acc.index) < HEALTH_SLOTS) begin
                    rd_word = health_code[int'(acc.index)];
                end
            end
            ITEM_FAN_HEALTH: rd_word = fan_code;
            ITEM_MODEL_STR: rd_word = sysio_char(MODEL_TEXT, acc.index);
            ITEM_FW_STR: rd_word = sysio_char(FW_TEXT, acc.index);
            default: rd_word = 16'h0000;
        endcase
    end

    // every request, read or write, is answered one cycle later
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acc_ack_r <= 1'b0;
        end else begin
            acc_ack_r <= acc.req;
        end
    end

    // read data stands only beside the answer to a read; zero at other times
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acc_rdata_r <= 16'h0000;
        end else if (acc.req && !acc.wr) begin
            acc_rdata_r <= rd_word;
        end else begin
            acc_rdata_r <= 16'h0000;
        end
    end

endmodule : sysio_bank

// ===== src/sysio_sync.sv
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/100ps
module sysio_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // one two-stage chain per bit; only the second stage is read outside
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic meta_r;
            logic stable_r;
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_r <= 1'b0;
                    stable_r <= 1'b0;
                end else begin
                    meta_r <= async_in[g];
                    stable_r <= meta_r;
                end
            end
            assign sync_out[g] = stable_r;
        end
    endgenerate

endmodule : sysio_sync
